// ---- src/fcw_cal_words.sv ----
/*
 * Factory calibration words: a read-only window at word addresses 2080h..208Fh
 * of program memory, answered on the flash read path.
 * Assumes requests come from logic on clk_i; writes come from the same path.
 */
// What this block does
// - Read-only calibration region 2080h to 208Fh
// - Word 2080h bits 11:8 diff amp trim
// - Word 2080h bits 6:0 oscillator trim
// - Word 2080h bit 7 reads zero
// - Bits 13:12 zero in 2080h, 2082h, 2083h
// - Word 2082h bits 11:8 reference offset trim
// - Word 2082h bits 3:0 bandgap, 7:4 zero
// - Word 2083h bits 11:8 thermal threshold trim
// - Word 2083h bits 3:0 error amp trim
// - Word 2084h bits 9:0 sensor reading
`timescale 1ns/1ps
module fcw_cal_words #(
    parameter logic [15:0][13:0] CAL_WORDS = {16{fcw_pkg::ERASED_WORD}}
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rd_req_i,
    input wire logic [13:0] rd_addr_i,
    input wire logic wr_req_i,
    input wire logic [13:0] wr_addr_i,
    output logic [13:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_hit_o,
    output logic wr_blocked_o
);
    typedef struct packed {
        logic pend;
        logic pend_hit;
        logic [3:0] pend_idx;
        logic [13:0] rd_data;
        logic rd_valid;
        logic rd_hit;
        logic wr_blocked;
    } fcw_state_s;

    fcw_state_s st;
    fcw_state_s next_st;
    fcw_rom_if rom_port ();

    logic rd_in_region;
    logic wr_in_region;

    assign rd_in_region = rd_addr_i[13:4] == fcw_pkg::CAL_BASE[13:4];
    assign wr_in_region = wr_addr_i[13:4] == fcw_pkg::CAL_BASE[13:4];

    assign rom_port.rd_en = rd_req_i && rd_in_region;
    assign rom_port.index = rd_addr_i[3:0];

    fcw_cal_rom #(
        .CONTENTS(CAL_WORDS)
    ) u_rom (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .port(rom_port)
    );

    always_comb begin
        next_st = st;
        next_st.pend = rd_req_i;
        next_st.pend_hit = rd_req_i && rd_in_region;
        next_st.pend_idx = rd_addr_i[3:0];
        next_st.rd_valid = st.pend;
        next_st.rd_hit = st.pend && st.pend_hit;
        // Unimplemented bits forced low; outside the region reads zero
        if (st.pend && st.pend_hit) begin
            next_st.rd_data = rom_port.data & fcw_pkg::word_mask(st.pend_idx);
        end else if (st.pend) begin
            next_st.rd_data = fcw_pkg::RESET_DATA;
        end
        // Nothing is stored on a write; one to the region is only reported
        next_st.wr_blocked = wr_req_i && wr_in_region;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{pend: 1'b0, pend_hit: 1'b0, pend_idx: 4'h0, rd_data: fcw_pkg::RESET_DATA,
                    rd_valid: 1'b0, rd_hit: 1'b0, wr_blocked: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign rd_data_o = st.rd_data;
    assign rd_valid_o = st.rd_valid;
    assign rd_hit_o = st.rd_hit;
    assign wr_blocked_o = st.wr_blocked;

    function automatic logic [13:0] expected(input logic [3:0] idx);
        return CAL_WORDS[idx] & fcw_pkg::word_mask(idx);
    endfunction : expected

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_read(logic [13:0] a);
        rd_req_i && rd_addr_i == a ##2 rd_valid_o;
    endsequence

    sequence s_read_any_hit;
        rd_req_i && rd_in_region ##2 rd_valid_o;
    endsequence

    sequence s_read_miss;
        rd_req_i && !rd_in_region ##2 rd_valid_o;
    endsequence

    sequence s_read_gap;
        rd_req_i && rd_in_region && fcw_pkg::word_mask(rd_addr_i[3:0]) == fcw_pkg::MASK_NONE ##2 rd_valid_o;
    endsequence

    sequence s_read_single;
        rd_req_i ##1 !rd_req_i;
    endsequence

    sequence s_read_pair;
        rd_req_i ##1 rd_req_i;
    endsequence

    sequence s_write_hit;
        wr_req_i && wr_in_region;
    endsequence

    chk_read_latency: assert property (rd_req_i |-> ##2 rd_valid_o && (rd_hit_o == $past(rd_in_region, 2)))
        else $error("read answer not two cycles after request");

    chk_valid_cause: assert property (rd_valid_o |-> $past(rd_req_i, 2))
        else $error("read answer without a request");

    chk_miss_zero: assert property (rd_valid_o && !rd_hit_o |-> rd_data_o == 14'h0000)
        else $error("read outside region returned data");

    chk_hit_contents: assert property (s_read_any_hit |-> rd_data_o == expected($past(rd_addr_i[3:0], 2)))
        else $error("read data differs from masked stored word");

    chk_word1_fields: assert property (s_read(fcw_pkg::ADDR_AMP_OSC) |->
        rd_data_o[11:8] == CAL_WORDS[0][11:8] && rd_data_o[6:0] == CAL_WORDS[0][6:0])
        else $error("amp offset or oscillator trim wrong");

    chk_word1_zeros: assert property (s_read(fcw_pkg::ADDR_AMP_OSC) |->
        rd_data_o[7] == 1'b0 && rd_data_o[13:12] == 2'b00)
        else $error("unimplemented bits of first word not zero");

    chk_word2_fields: assert property (s_read(fcw_pkg::ADDR_REF_BANDGAP) |->
        rd_data_o[11:8] == CAL_WORDS[2][11:8] && rd_data_o[3:0] == CAL_WORDS[2][3:0]
        && rd_data_o[7:4] == 4'h0 && rd_data_o[13:12] == 2'b00)
        else $error("reference or bandgap word wrong");

    chk_word3_fields: assert property (s_read(fcw_pkg::ADDR_THERMAL_ERRAMP) |->
        rd_data_o[11:8] == CAL_WORDS[3][11:8] && rd_data_o[3:0] == CAL_WORDS[3][3:0]
        && rd_data_o[7:4] == 4'h0 && rd_data_o[13:12] == 2'b00)
        else $error("thermal or error amp word wrong");

    chk_word4_fields: assert property (s_read(fcw_pkg::ADDR_TEMP_SENSOR) |->
        rd_data_o[9:0] == CAL_WORDS[4][9:0] && rd_data_o[13:10] == 4'h0)
        else $error("sensor reading word wrong");

    chk_write_blocked: assert property (wr_req_i && wr_in_region |=> wr_blocked_o ##1 !wr_blocked_o || $past(wr_req_i))
        else $error("write to calibration region not reported");

    chk_write_no_effect: assert property (wr_req_i ##1 rd_req_i && rd_in_region |-> ##2
        rd_data_o == expected($past(rd_addr_i[3:0], 2)))
        else $error("write altered calibration contents");

    // Address decode against the region bounds
    chk_read_bounds: assert property (rd_in_region ==
        (rd_addr_i >= fcw_pkg::CAL_BASE && rd_addr_i <= fcw_pkg::CAL_LAST))
        else $error("read region decode wrong");

    chk_write_bounds: assert property (wr_in_region ==
        (wr_addr_i >= fcw_pkg::CAL_BASE && wr_addr_i <= fcw_pkg::CAL_LAST))
        else $error("write region decode wrong");

    // Answer shape: one pulse per request, data stands in between
    chk_hit_needs_valid: assert property (rd_hit_o |-> rd_valid_o)
        else $error("hit flag without read answer");

    chk_valid_pulse: assert property (s_read_single |-> ##2 !rd_valid_o)
        else $error("read answer stood longer than one cycle");

    chk_back_to_back: assert property (s_read_pair |-> ##1 rd_valid_o ##1 rd_valid_o)
        else $error("back-to-back reads not answered on consecutive cycles");

    chk_data_holds: assert property (!rd_valid_o |-> $stable(rd_data_o))
        else $error("read data changed without an answer");

    chk_miss_flags: assert property (s_read_miss |-> !rd_hit_o && rd_data_o == 14'h0000)
        else $error("read outside region flagged as hit");

    chk_gap_words_zero: assert property (s_read_gap |-> rd_data_o == 14'h0000)
        else $error("unused word in region returned data");

    chk_store_read: assert property (rom_port.rd_en |=> rom_port.data == CAL_WORDS[$past(rom_port.index)])
        else $error("word store returned wrong entry");

    // Write attempts: flagged once if in the region, never stored
    chk_blocked_cause: assert property (wr_blocked_o |-> $past(wr_req_i) && $past(wr_in_region))
        else $error("write flag without a write to the region");

    chk_blocked_pulse: assert property (s_write_hit ##1 !wr_req_i |=> !wr_blocked_o)
        else $error("write flag stood longer than one cycle");

    chk_outside_write: assert property (wr_req_i && !wr_in_region |=> !wr_blocked_o)
        else $error("write outside region flagged");

    // Every word of the region reads zero outside its implemented bits
    for (genvar g = 0; g < fcw_pkg::NUM_WORDS; g++) begin : g_word_chk
        chk_unimpl_zero: assert property (s_read(fcw_pkg::CAL_BASE + 14'(g)) |->
            (rd_data_o & ~fcw_pkg::word_mask(4'(g))) == 14'h0000)
            else $error("unimplemented bit of a calibration word read as one");
        chk_word_contents: assert property (s_read(fcw_pkg::CAL_BASE + 14'(g)) |->
            rd_hit_o && rd_data_o == (CAL_WORDS[g] & fcw_pkg::word_mask(4'(g))))
            else $error("calibration word differs from stored contents");
    end
endmodule : fcw_cal_words

// ---- src/fcw_pkg.sv ----
/*
 * Constants for the factory calibration word store: the region it answers,
 * the word offsets, the implemented-bit masks and the field positions.
 * Assumes word addressing, with 14-bit addresses and 14-bit words.
 */
package fcw_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 14;
    localparam int IDX_W = 4;
    localparam int NUM_WORDS = 16;

    // Region 2080h..208Fh
    localparam logic [13:0] CAL_BASE = 14'h2080;
    localparam logic [13:0] CAL_LAST = 14'h208f;

    localparam logic [13:0] ADDR_AMP_OSC = 14'h2080;
    localparam logic [13:0] ADDR_REF_BANDGAP = 14'h2082;
    localparam logic [13:0] ADDR_THERMAL_ERRAMP = 14'h2083;
    localparam logic [13:0] ADDR_TEMP_SENSOR = 14'h2084;

    localparam logic [3:0] IDX_AMP_OSC = 4'h0;
    localparam logic [3:0] IDX_REF_BANDGAP = 4'h2;
    localparam logic [3:0] IDX_THERMAL_ERRAMP = 4'h3;
    localparam logic [3:0] IDX_TEMP_SENSOR = 4'h4;

    // Implemented bits of each word; the rest read as zero
    localparam logic [13:0] MASK_AMP_OSC = 14'h0f7f;
    localparam logic [13:0] MASK_REF_BANDGAP = 14'h0f0f;
    localparam logic [13:0] MASK_THERMAL_ERRAMP = 14'h0f0f;
    localparam logic [13:0] MASK_TEMP_SENSOR = 14'h03ff;
    localparam logic [13:0] MASK_NONE = 14'h0000;

    // Field positions (low bit)
    localparam int DIFF_AMP_OFFSET_TRIM_LSB = 8;
    localparam int OSCILLATOR_TRIM_LSB = 0;
    localparam int REFERENCE_BUFFER_OFFSET_TRIM_LSB = 8;
    localparam int BANDGAP_TRIM_LSB = 0;
    localparam int THERMAL_THRESHOLD_TRIM_LSB = 8;
    localparam int ERROR_AMP_OFFSET_TRIM_LSB = 0;
    localparam int TEMP_SENSOR_REF_READING_LSB = 0;

    // Erased, unprogrammed cells read as ones
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    localparam logic [13:0] RESET_DATA = 14'h0000;

    // Request edge to answer
    localparam int READ_LATENCY = 2;

    function automatic logic [13:0] word_mask(input logic [3:0] idx);
        logic [13:0] m;
        m = MASK_NONE;
        if (idx == IDX_AMP_OSC) m = MASK_AMP_OSC;
        else if (idx == IDX_REF_BANDGAP) m = MASK_REF_BANDGAP;
        else if (idx == IDX_THERMAL_ERRAMP) m = MASK_THERMAL_ERRAMP;
        else if (idx == IDX_TEMP_SENSOR) m = MASK_TEMP_SENSOR;
        return m;
    endfunction : word_mask

endpackage : fcw_pkg

// ---- src/fcw_rom_if.sv ----
/*
 * Read port between the calibration front end and its word store.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface fcw_rom_if;
    logic rd_en;
    logic [3:0] index;
    logic [13:0] data;

    modport requester (output rd_en, output index, input data);
    modport rom (input rd_en, input index, output data);
endinterface : fcw_rom_if

// ---- src/fcw_cal_rom.sv ----
/*
 * Sixteen-word factory calibration store, contents fixed at build time.
 * Read data come from a register one edge after rd_en. Assumes one clock.
 */
`timescale 1ns/1ps
module fcw_cal_rom #(
    parameter logic [15:0][13:0] CONTENTS = {16{fcw_pkg::ERASED_WORD}}
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    fcw_rom_if.rom port
);
    typedef struct packed {
        logic [13:0] q;
    } fcw_rom_state_s;

    fcw_rom_state_s st;
    fcw_rom_state_s next_st;

    always_comb begin
        next_st = st;
        if (port.rd_en) begin
            next_st.q = CONTENTS[port.index];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{q: fcw_pkg::RESET_DATA};
        end else begin
            st <= next_st;
        end
    end

    assign port.data = st.q;
endmodule : fcw_cal_rom

// ---- verif/tb_fcw_cal_words.sv ----
/*
 * Self-checking bench for the calibration word store: reads every word of the
 * region and some outside it, back-to-back reads and blocked writes.
 * Assumes the two-cycle read latency and one-cycle write flag of the design.
 */
`timescale 1ns/1ps
module tb_fcw_cal_words;
    localparam logic [15:0][13:0] CAL = {{11{14'h3fff}}, 14'h2e3b, 14'h35a7, 14'h3c96, 14'h3fff, 14'h3ad5};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic [13:0] rd_addr_i = 14'h0000;
    logic wr_req_i = 1'b0;
    logic [13:0] wr_addr_i = 14'h0000;
    logic [13:0] rd_data_o;
    logic rd_valid_o;
    logic rd_hit_o;
    logic wr_blocked_o;
    int fails = 0;
    int comparisons = 0;
    logic [3:0] diff_amp_trim_reg;
    logic [9:0] temp_sensor_ref_reading;

    fcw_cal_words #(.CAL_WORDS(CAL)) u_fcw_cal_words (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req_i),
        .rd_addr_i(rd_addr_i), .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o), .wr_blocked_o(wr_blocked_o));

    always #25 clk_i = ~clk_i;

    // Expected word: stored value with unimplemented bits cleared
    function automatic logic [13:0] exp_rd(input logic [13:0] a);
        logic [13:0] w;
        w = 14'h0000;
        if (a == 14'h2080) w = CAL[0] & 14'h0f7f;
        if (a == 14'h2082) w = CAL[2] & 14'h0f0f;
        if (a == 14'h2083) w = CAL[3] & 14'h0f0f;
        if (a == 14'h2084) w = CAL[4] & 14'h03ff;
        return w;
    endfunction : exp_rd

    task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_flag

    task automatic rd(input logic [13:0] a);
        @(negedge clk_i);
        rd_req_i = 1'b1;
        rd_addr_i = a;
        @(negedge clk_i);
        rd_req_i = 1'b0;
        rd_addr_i = ~a;
        @(posedge clk_i);
        #1;
        check_flag(rd_valid_o, 1'b1);
        check_flag(rd_hit_o, (a >= 14'h2080) && (a <= 14'h208f));
        check_word(rd_data_o, exp_rd(a));
        @(posedge clk_i);
        #1;
        check_flag(rd_valid_o, 1'b0);
        check_word(rd_data_o, exp_rd(a));
    endtask : rd

    task automatic wr(input logic [13:0] a, input logic blk);
        @(negedge clk_i);
        wr_req_i = 1'b1;
        wr_addr_i = a;
        @(posedge clk_i);
        #1;
        check_flag(wr_blocked_o, blk);
        @(negedge clk_i);
        wr_req_i = 1'b0;
        wr_addr_i = ~a;
        @(posedge clk_i);
        #1;
        check_flag(wr_blocked_o, 1'b0);
    endtask : wr

    task automatic final_report;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #(3000 * 50);
        fails++;
        final_report();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        check_word(rd_data_o, 14'h0000);
        check_flag(rd_valid_o, 1'b0);
        rst_n_i = 1'b1;
        rd(14'h2080);
        diff_amp_trim_reg = rd_data_o[11:8];
        check_word({10'h000, diff_amp_trim_reg}, {10'h000, CAL[0][11:8]});
        rd(14'h2082);
        rd(14'h2083);
        rd(14'h2084);
        temp_sensor_ref_reading = rd_data_o[9:0];
        check_word({4'h0, temp_sensor_ref_reading}, {4'h0, CAL[4][9:0]});
        for (int i = 0; i < 16; i++) begin
            rd(14'h2080 + 14'(i));
        end
        rd(14'h207f);
        rd(14'h2090);
        rd(14'h0000);
        wr(14'h2080, 1'b1);
        wr(14'h208f, 1'b1);
        wr(14'h2090, 1'b0);
        rd(14'h2080);
        // Back-to-back reads are answered in order, one per cycle
        @(negedge clk_i);
        rd_req_i = 1'b1;
        rd_addr_i = 14'h2082;
        @(negedge clk_i);
        rd_addr_i = 14'h2084;
        @(negedge clk_i);
        rd_req_i = 1'b0;
        check_flag(rd_valid_o, 1'b1);
        check_word(rd_data_o, CAL[2] & 14'h0f0f);
        @(posedge clk_i);
        #1;
        check_flag(rd_valid_o, 1'b1);
        check_word(rd_data_o, CAL[4] & 14'h03ff);
        // A write just before a read leaves the read answer untouched
        @(negedge clk_i);
        wr_req_i = 1'b1;
        wr_addr_i = 14'h2083;
        @(negedge clk_i);
        wr_req_i = 1'b0;
        rd_req_i = 1'b1;
        rd_addr_i = 14'h2083;
        check_flag(wr_blocked_o, 1'b1);
        @(negedge clk_i);
        rd_req_i = 1'b0;
        @(posedge clk_i);
        #1;
        check_flag(rd_valid_o, 1'b1);
        check_word(rd_data_o, CAL[3] & 14'h0f0f);
        repeat (3) @(negedge clk_i);
        final_report();
    end
endmodule : tb_fcw_cal_words
